// >>> hw/usb_ep_ctrl.sv
// Endpoint control/status registers and their hardware flags for one endpoint.
// Assumes AHB-Lite single word transfers and a packet engine on the same clock.
//
// Overview of operation
// - Flag incomplete split iso transmit, peripheral role
// - Incomplete-transmit reads zero unless isochronous
// - Host: NAK limit exceeded halts, flags time-out
// - Clear-toggle write one zeroes data toggle
// - Stall sent: flag, flush, clear packet-ready
// - Stall received: flag, abort DMA, flush
// - Send-stall answers IN with STALL, not iso
// - Setup select with ready: SETUP token, toggle zero
// - Flush drops latest packet, clears ready, interrupts
// - IN token with no tx packet held sets underrun
// - Three tx attempts without handshake set error
// - Tx not-empty shows packets held
// - Packet-ready set by software, cleared by hardware
// - Iso OUT packet not loadable sets overrun
// - Three rx attempts without data set error
// - Rx full when no packet slot free
// - Received packet sets ready and interrupts
// - Payload is max payload times multiplier+1
// - Bulk multiplier splits FIFO packet, software aligns
// - High-speed periodic multiplier is two or three
// - Eleven-bit max payload field per transaction
`timescale 1ns/1ps
`default_nettype none

module usb_ep_ctrl #(
   parameter logic [1:0] TX_SLOTS = 2'h2,  // Tx packets held (double buffer)
   parameter logic [1:0] RX_SLOTS = 2'h2   // Rx packets held
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic HSEL_IN,
   input wire logic [31:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire usb_ep_pkg::link_evt_t EVT_IN,
   output usb_ep_pkg::link_ctl_t CTL_OUT
);
   import usb_ep_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [31:0] hrdata;        // Read data for the data phase
      logic wr_pend;              // Write data phase due
      logic [7:0] wr_addr;        // Address of pending write
      logic host;                 // Operating role
      xfer_t tx_type;
      xfer_t rx_type;
      logic [NAK_W-1:0] nak_limit;
      logic flag_hi;              // Incomplete-tx or NAK time-out
      logic stall_flag;           // Stall sent or received
      logic stall_ctl;            // Send stall or setup select
      logic tx_err;               // Underrun or handshake failure
      logic tpr;                  // Tx packet ready
      logic tpr_load;             // Packet moving into buffer
      logic [1:0] tx_cnt;         // Tx packets held
      logic [PACKET_MULTIPLIER_W-1:0] tx_packet_multiplier;
      logic [MAXP_W-1:0] tx_maxp;
      logic rx_err;               // Overrun or no-data error
      logic rpr;                  // Rx packet ready
      logic [1:0] rx_cnt;         // Rx packets held
      logic [PACKET_MULTIPLIER_W-1:0] rx_packet_multiplier;
      logic [MAXP_W-1:0] rx_maxp;
      logic toggle;               // Tx data toggle
      logic [1:0] tx_retry;       // Failed tx attempts
      logic [1:0] rx_retry;       // Failed rx attempts
      logic [NAK_W-1:0] nak_cnt;  // NAKs since last success
      link_ctl_t ctl;             // Registered engine controls
   } state_t;

   state_t s_ff;   // Current state
   state_t nxt_s;  // Next state

   // ************************************************************
   // Helper functions
   // ************************************************************
   // Payload in bytes; shared by tx and rx sizing
   function automatic logic [PAY_W-1:0] payload(input logic [MAXP_W-1:0] maxp,
                                                input logic [PACKET_MULTIPLIER_W-1:0] packet_multiplier);
      logic [PAY_W-1:0] m;
      m = PAY_W'(packet_multiplier) + PAY_W'(1);
      return PAY_W'(PAY_W'(maxp) * m);
   endfunction

   // Register read view; role and type mask shared bits
   function automatic logic [31:0] rd_word(input state_t st, input logic [7:0] a);
      logic [31:0] w;
      w = RDATA_RST;
      if (a == TX_CSR_OFS) begin
         w[BIT_FLAG_HI] = st.flag_hi & (st.host | (st.tx_type == XFER_ISO));
         w[BIT_STALL_FLG] = st.stall_flag;
         w[BIT_STALL_CTL] = st.stall_ctl;
         w[BIT_ERR] = st.tx_err;
         w[BIT_FIFO] = (st.tx_cnt != 2'h0);
         w[BIT_RDY] = st.tpr;
         w[PACKET_MULTIPLIER_LSB +: PACKET_MULTIPLIER_W] = st.tx_packet_multiplier;
         w[MAXP_W-1:0] = st.tx_maxp;
      end else if (a == RX_CSR_OFS) begin
         if (st.host) begin
            w[BIT_ERR] = st.rx_err & (st.rx_type != XFER_ISO);
         end else begin
            w[BIT_ERR] = st.rx_err & (st.rx_type == XFER_ISO);
         end
         w[BIT_FIFO] = (st.rx_cnt == RX_SLOTS);
         w[BIT_RDY] = st.rpr;
         w[PACKET_MULTIPLIER_LSB +: PACKET_MULTIPLIER_W] = st.rx_packet_multiplier;
         w[MAXP_W-1:0] = st.rx_maxp;
      end else if (a == CFG_OFS) begin
         w[CFG_HOST] = st.host;
         w[CFG_TXT_LSB +: 2] = st.tx_type;
         w[CFG_RXT_LSB +: 2] = st.rx_type;
         w[CFG_NAK_LSB +: NAK_W] = st.nak_limit;
      end
      return w;
   endfunction

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // Writes are applied first so hardware events that follow win
   always_comb begin
      logic [31:0] wd;
      logic wr_tx;
      logic wr_rx;
      logic wr_cfg;
      logic t_inc;
      logic t_dec;
      logic t_zero;
      logic r_inc;
      logic r_dec;
      wd = HWDATA_IN;
      nxt_s = s_ff;
      nxt_s.ctl.tx_flush = 1'b0;
      nxt_s.ctl.dma_abort = 1'b0;
      nxt_s.ctl.ep_irq = 1'b0;
      wr_tx = s_ff.wr_pend && (s_ff.wr_addr == TX_CSR_OFS);
      wr_rx = s_ff.wr_pend && (s_ff.wr_addr == RX_CSR_OFS);
      wr_cfg = s_ff.wr_pend && (s_ff.wr_addr == CFG_OFS);
      t_inc = 1'b0;
      t_dec = 1'b0;
      t_zero = 1'b0;
      r_inc = 1'b0;
      r_dec = 1'b0;

      if (s_ff.tpr_load) begin
         nxt_s.tpr_load = 1'b0;
         if (s_ff.tx_cnt < TX_SLOTS) begin
            nxt_s.tpr = 1'b0;
         end
      end

      // Configuration write
      if (wr_cfg) begin
         nxt_s.host = wd[CFG_HOST];
         nxt_s.tx_type = xfer_t'(wd[CFG_TXT_LSB +: 2]);
         nxt_s.rx_type = xfer_t'(wd[CFG_RXT_LSB +: 2]);
         nxt_s.nak_limit = wd[CFG_NAK_LSB +: NAK_W];
      end

      // Transmit register write
      if (wr_tx) begin
         nxt_s.tx_packet_multiplier = wd[PACKET_MULTIPLIER_LSB +: PACKET_MULTIPLIER_W];
         nxt_s.tx_maxp = wd[MAXP_W-1:0];
         nxt_s.stall_ctl = wd[BIT_STALL_CTL];
         // Status flags clear on a written zero
         if (!wd[BIT_FLAG_HI]) begin
            nxt_s.flag_hi = 1'b0;
            nxt_s.ctl.tx_halt = 1'b0;
            nxt_s.nak_cnt = '0;
         end
         if (!wd[BIT_STALL_FLG]) begin
            nxt_s.stall_flag = 1'b0;
         end
         if (!wd[BIT_ERR]) begin
            nxt_s.tx_err = 1'b0;
         end
         if (wd[BIT_CLR_TOG]) begin
            nxt_s.toggle = 1'b0;
         end
         if (wd[BIT_RDY] && !s_ff.tpr && (s_ff.tx_cnt < TX_SLOTS)) begin
            nxt_s.tpr = 1'b1;
            nxt_s.tpr_load = 1'b1;
            t_inc = 1'b1;
            if (s_ff.host && wd[BIT_STALL_CTL]) begin
               nxt_s.toggle = 1'b0;
            end
         end
         if (wd[BIT_FLUSH]) begin
            nxt_s.tpr = 1'b0;
            nxt_s.tpr_load = 1'b0;
            nxt_s.ctl.tx_flush = 1'b1;
            nxt_s.ctl.ep_irq = 1'b1;
            t_dec = 1'b1;
         end
      end

      if (wr_rx) begin
         nxt_s.rx_packet_multiplier = wd[PACKET_MULTIPLIER_LSB +: PACKET_MULTIPLIER_W];
         nxt_s.rx_maxp = wd[MAXP_W-1:0];
         if (!wd[BIT_ERR]) begin
            nxt_s.rx_err = 1'b0;
         end
         if (!wd[BIT_RDY] && s_ff.rpr) begin
            r_dec = 1'b1;
         end
      end

      // Transmit completion from the engine
      if (EVT_IN.tx_pkt_sent) begin
         nxt_s.tpr = 1'b0;
         nxt_s.toggle = ~nxt_s.toggle;
         nxt_s.tx_retry = 2'h0;
         nxt_s.nak_cnt = '0;
         t_dec = 1'b1;
      end

      if (!s_ff.host) begin
         if (EVT_IN.stall_hs_sent) begin
            nxt_s.stall_flag = 1'b1;
            nxt_s.tpr = 1'b0;
            nxt_s.ctl.tx_flush = 1'b1;
            t_zero = 1'b1;
         end
         if (EVT_IN.in_token && !s_ff.tpr && (s_ff.tx_cnt == 2'h0)) begin
            nxt_s.tx_err = 1'b1;
         end
         if (EVT_IN.iso_parts_short && (s_ff.tx_type == XFER_ISO)) begin
            nxt_s.flag_hi = 1'b1;
         end
      end else begin
         if (EVT_IN.stall_hs_rcvd) begin
            nxt_s.stall_flag = 1'b1;
            nxt_s.tpr = 1'b0;
            nxt_s.ctl.tx_flush = 1'b1;
            nxt_s.ctl.dma_abort = 1'b1;
            t_zero = 1'b1;
         end
         if (EVT_IN.nak_rcvd) begin
            if (s_ff.nak_cnt != {NAK_W{1'b1}}) begin
               nxt_s.nak_cnt = s_ff.nak_cnt + 8'h01;
            end
            if ((s_ff.nak_limit != '0) && (s_ff.nak_cnt >= s_ff.nak_limit)) begin
               nxt_s.flag_hi = 1'b1;
               nxt_s.ctl.tx_halt = 1'b1;
            end
         end
         if (EVT_IN.tx_no_handshake) begin
            if (s_ff.tx_retry == RETRY_LIMIT - 2'h1) begin
               nxt_s.tx_err = 1'b1;
               nxt_s.tx_retry = 2'h0;
            end else begin
               nxt_s.tx_retry = s_ff.tx_retry + 2'h1;
            end
         end
         if (EVT_IN.rx_no_data && (s_ff.rx_type != XFER_ISO)) begin
            if (s_ff.rx_retry == RETRY_LIMIT - 2'h1) begin
               nxt_s.rx_err = 1'b1;
               nxt_s.rx_retry = 2'h0;
               nxt_s.ctl.ep_irq = 1'b1;
            end else begin
               nxt_s.rx_retry = s_ff.rx_retry + 2'h1;
            end
         end
      end

      // Receive packet arrival
      if (EVT_IN.rx_data_pkt) begin
         if (s_ff.rx_cnt == RX_SLOTS) begin
            if (!s_ff.host && (s_ff.rx_type == XFER_ISO)) begin
               nxt_s.rx_err = 1'b1;
            end
         end else begin
            r_inc = 1'b1;
            nxt_s.ctl.ep_irq = 1'b1;
            nxt_s.rx_retry = 2'h0;
         end
      end

      // Packet counts; a stall flush empties the FIFO outright
      if (t_zero) begin
         nxt_s.tx_cnt = 2'h0;
      end else if (t_inc && !t_dec) begin
         nxt_s.tx_cnt = s_ff.tx_cnt + 2'h1;
      end else if (!t_inc && t_dec && (s_ff.tx_cnt != 2'h0)) begin
         nxt_s.tx_cnt = s_ff.tx_cnt - 2'h1;
      end
      if (r_inc && !r_dec) begin
         nxt_s.rx_cnt = s_ff.rx_cnt + 2'h1;
      end else if (!r_inc && r_dec && (s_ff.rx_cnt != 2'h0)) begin
         nxt_s.rx_cnt = s_ff.rx_cnt - 2'h1;
      end
      // Ready stays while packets remain, so an arrival beats a clear
      nxt_s.rpr = (nxt_s.rx_cnt != 2'h0);

      // Registered controls toward the packet engine
      // Stall only outside iso
      nxt_s.ctl.respond_stall = !nxt_s.host && nxt_s.stall_ctl
                                && (nxt_s.tx_type != XFER_ISO);
      nxt_s.ctl.send_setup = nxt_s.host && nxt_s.stall_ctl;
      nxt_s.ctl.data_toggle = nxt_s.toggle;
      nxt_s.ctl.tx_pkt_avail = (nxt_s.tx_cnt != 2'h0) && !nxt_s.ctl.tx_halt;
      nxt_s.ctl.rx_full = (nxt_s.rx_cnt == RX_SLOTS);
      nxt_s.ctl.tx_payload = payload(nxt_s.tx_maxp, nxt_s.tx_packet_multiplier);
      nxt_s.ctl.rx_payload = payload(nxt_s.rx_maxp, nxt_s.rx_packet_multiplier);

      // AHB address phase; read data taken from the updated state
      // so a read right after a write sees the written value
      nxt_s.wr_pend = 1'b0;
      nxt_s.hrdata = RDATA_RST;
      if (HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ)) begin
         nxt_s.wr_pend = HWRITE_IN;
         nxt_s.wr_addr = HADDR_IN[7:0];
         if (!HWRITE_IN) begin
            nxt_s.hrdata = rd_word(nxt_s, HADDR_IN[7:0]);
         end
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Zero wait states and OKAY only: every access completes at once
   assign HRDATA_OUT = s_ff.hrdata;
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT = 1'b0;
   assign CTL_OUT = s_ff.ctl;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   AST_UNDERRUN: assert property (EVT_IN.in_token && !s_ff.host && !s_ff.tpr
      && (s_ff.tx_cnt == 2'h0) |=> s_ff.tx_err)
      else $error("Underrun not flagged");
   AST_STALL_SENT: assert property (EVT_IN.stall_hs_sent && !s_ff.host
      |=> s_ff.stall_flag && !s_ff.tpr && (s_ff.tx_cnt == 2'h0) && CTL_OUT.tx_flush)
      else $error("Stall sent did not flush");
   AST_STALL_RCVD: assert property (EVT_IN.stall_hs_rcvd && s_ff.host
      |=> CTL_OUT.dma_abort && s_ff.stall_flag ##1 !CTL_OUT.dma_abort)
      else $error("Stall received did not abort");
   AST_CLR_TOGGLE: assert property (s_ff.wr_pend && (s_ff.wr_addr == TX_CSR_OFS)
      && HWDATA_IN[BIT_CLR_TOG] && !EVT_IN.tx_pkt_sent |=> !CTL_OUT.data_toggle)
      else $error("Toggle not cleared");
   AST_FLUSH: assert property (s_ff.wr_pend && (s_ff.wr_addr == TX_CSR_OFS)
      && HWDATA_IN[BIT_FLUSH] |=> CTL_OUT.tx_flush && CTL_OUT.ep_irq && !s_ff.tpr)
      else $error("Flush effects missing");
   AST_STALL_ISO: assert property (s_ff.tx_type == XFER_ISO
      |-> !CTL_OUT.respond_stall)
      else $error("Stall answered on iso endpoint");
   AST_RX_ERR: assert property (EVT_IN.rx_no_data && s_ff.host
      && (s_ff.rx_type != XFER_ISO) && (s_ff.rx_retry == RETRY_LIMIT - 2'h1)
      |=> s_ff.rx_err && CTL_OUT.ep_irq)
      else $error("Rx error missed after three attempts");
   AST_RX_READY: assert property (EVT_IN.rx_data_pkt && (s_ff.rx_cnt != RX_SLOTS)
      |=> s_ff.rpr && CTL_OUT.ep_irq)
      else $error("Rx ready not raised");
   AST_NAK_HALT: assert property (EVT_IN.nak_rcvd && s_ff.host
      && (s_ff.nak_limit != '0) && (s_ff.nak_cnt >= s_ff.nak_limit)
      |=> CTL_OUT.tx_halt && s_ff.flag_hi && !CTL_OUT.tx_pkt_avail)
      else $error("NAK time-out did not halt");
   AST_PAYLOAD: assert property ($changed(s_ff.rx_packet_multiplier)
      |-> CTL_OUT.rx_payload == PAY_W'(PAY_W'(s_ff.rx_maxp) * (PAY_W'(s_ff.rx_packet_multiplier) + PAY_W'(1))))
      else $error("Payload size wrong");

endmodule

`default_nettype wire

// >>> hw/usb_ep_pkg.sv
// Shared constants and carrier types for the endpoint control/status block.
// Assumes a single 200 MHz clock domain and an AHB-Lite register port.
package usb_ep_pkg;

   // ************************************************************
   // Register map (byte addresses, low address byte only)
   // ************************************************************
   localparam logic [7:0] TX_CSR_OFS = 8'h00;  // Transmit control/status
   localparam logic [7:0] RX_CSR_OFS = 8'h04;  // Receive control/status
   localparam logic [7:0] CFG_OFS = 8'h08;     // Role, types, NAK limit

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_FLAG_HI = 23;    // Incomplete-tx / NAK time-out
   localparam int BIT_CLR_TOG = 22;    // Clear data toggle (action)
   localparam int BIT_STALL_FLG = 21;  // Stall sent / stall received
   localparam int BIT_STALL_CTL = 20;  // Send stall / setup select
   localparam int BIT_FLUSH = 19;      // Flush (action)
   localparam int BIT_ERR = 18;        // Underrun/error, overrun/error
   localparam int BIT_FIFO = 17;       // Tx not empty / rx full
   localparam int BIT_RDY = 16;        // Packet ready
   localparam int PACKET_MULTIPLIER_LSB = 11;       // Packet multiplier 15:11
   localparam int PACKET_MULTIPLIER_W = 5;
   localparam int MAXP_W = 11;         // Max payload 10:0
   localparam int CFG_HOST = 0;        // 1 = host role
   localparam int CFG_TXT_LSB = 1;     // Tx transfer type 2:1
   localparam int CFG_RXT_LSB = 3;     // Rx transfer type 4:3
   localparam int CFG_NAK_LSB = 8;     // NAK limit 15:8
   localparam int NAK_W = 8;
   localparam int PAY_W = 17;          // Max payload times 32

   // ************************************************************
   // Reset values and protocol constants
   // ************************************************************
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   localparam logic [1:0] RETRY_LIMIT = 2'h3;  // Failed attempts before error
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // Endpoint transfer type
   typedef enum logic [1:0] {
      XFER_CTRL = 2'h0,
      XFER_ISO = 2'h1,
      XFER_BULK = 2'h2,
      XFER_INT = 2'h3
   } xfer_t;

   // Events from the packet engine, one-cycle pulses
   typedef struct packed {
      logic in_token;         // IN token arrived (peripheral)
      logic stall_hs_sent;    // STALL handshake sent (peripheral)
      logic stall_hs_rcvd;    // STALL handshake received (host)
      logic tx_pkt_sent;      // Tx packet acknowledged
      logic tx_no_handshake;  // Tx attempt got no handshake (host)
      logic nak_rcvd;         // NAK received (host)
      logic iso_parts_short;  // Split iso packet lacked IN tokens
      logic rx_data_pkt;      // Rx data packet arrived
      logic rx_no_data;       // Rx attempt got no data (host)
   } link_evt_t;

   // Controls to the packet engine, all registered
   typedef struct packed {
      logic respond_stall;      // Answer IN tokens with STALL
      logic send_setup;         // Use SETUP token instead of OUT
      logic data_toggle;        // Current tx data toggle
      logic tx_halt;            // Tx halted after NAK time-out
      logic tx_pkt_avail;       // A tx packet is queued and tx not halted
      logic rx_full;            // Rx FIFO cannot accept a packet
      logic tx_flush;           // Pulse: flush tx FIFO
      logic dma_abort;          // Pulse: stop DMA request
      logic ep_irq;             // Pulse: endpoint interrupt event
      logic [PAY_W-1:0] tx_payload;
      logic [PAY_W-1:0] rx_payload;
   } link_ctl_t;

endpackage

// >>> tb/usb_link_model.sv
// Behavioural packet engine facing the endpoint block's link side.
// Assumes the block's clock and its synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module usb_link_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire usb_ep_pkg::link_evt_t req_in,
   input wire usb_ep_pkg::link_ctl_t ctl_in,
   output usb_ep_pkg::link_evt_t evt_out,
   output logic [7:0] flush_cnt_out,
   output logic [7:0] irq_cnt_out,
   output logic [7:0] abort_cnt_out
);
   import usb_ep_pkg::*;
   // ************************************************************
   // Event replay and pulse counters
   // ************************************************************
   // Events last exactly one cycle, as the engine issues them; pulses
   // from the block are counted because a bench poll could miss them
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         evt_out <= '0;
         flush_cnt_out <= 8'h00;
         irq_cnt_out <= 8'h00;
         abort_cnt_out <= 8'h00;
      end else begin
         evt_out <= req_in;
         flush_cnt_out <= flush_cnt_out + {7'h00, ctl_in.tx_flush};
         irq_cnt_out <= irq_cnt_out + {7'h00, ctl_in.ep_irq};
         abort_cnt_out <= abort_cnt_out + {7'h00, ctl_in.dma_abort};
      end
   end
endmodule
`default_nettype wire

// >>> tb/usb_endpoint_ctrl_status_tb.sv
// Self-checking bench for the endpoint control/status block.
// Assumes the block answers on AHB-Lite and a link model drives its events.
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_ctrl_status_tb;
   import usb_ep_pkg::*;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, sink;
   logic [1:0] htrans = 2'h0;
   link_evt_t req = '0, evt;
   link_ctl_t ctl;
   logic [7:0] fl, irq, ab, f0, i0;
   int bad_count = 0;
   int tests_run = 0;
   typedef struct packed {logic [4:0] m; logic [10:0] p; logic [16:0] pay;} row_t;
   // Multiplier, even max payload, expected payload size
   row_t rows [4] = '{'{5'h00, 11'h002, 17'h00002}, '{5'h01, 11'h200, 17'h00400},
      '{5'h02, 11'h400, 17'h00C00}, '{5'h1F, 11'h7FE, 17'h0FFC0}};
   always #2.5 clk = ~clk;
   usb_ep_ctrl u_usb_ep_ctrl (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
      .EVT_IN(evt), .CTL_OUT(ctl));
   usb_link_model u_usb_link_model (.clk_in(clk), .rst_in(rst), .req_in(req), .ctl_in(ctl),
      .evt_out(evt), .flush_cnt_out(fl), .irq_cnt_out(irq), .abort_cnt_out(ab));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // Bounded wait for hready, so a stuck slave ends the run
   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n > 50) begin
            bad_count++;
            test_done();
         end
      end while (hready !== 1'b1);
   endtask
   // One single word transfer; read data taken at the data phase edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rv);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      rdy();
      rv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, sink);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   // Asks the link model for n single-cycle events, then lets them land
   task automatic ev(input link_evt_t e, input int n);
      repeat (n) begin
         @(posedge clk);
         req <= e;
         @(posedge clk);
         req <= '0;
      end
      repeat (2) @(posedge clk);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rc(TX_CSR_OFS, RDATA_RST);
      rc(RX_CSR_OFS, RDATA_RST);
      rc(8'h0C, 32'h0);
      chk("ctl", 32'h0, {31'h0, |ctl});
      chk("hresp", 32'h0, {31'h0, hresp});
      foreach (rows[i]) begin
         wr(TX_CSR_OFS, {16'h0, rows[i].m, rows[i].p});
         wr(RX_CSR_OFS, {16'h0, rows[i].m, rows[i].p});
         @(negedge clk);
         chk("tx pay", {15'h0, rows[i].pay}, {15'h0, ctl.tx_payload});
         chk("rx pay", {15'h0, rows[i].pay}, {15'h0, ctl.rx_payload});
         rc(RX_CSR_OFS, {16'h0, rows[i].m, rows[i].p});
      end
      wr(TX_CSR_OFS, 32'h0);
      wr(RX_CSR_OFS, 32'h0);
      // Peripheral role: underrun, then incomplete-transmit per type
      ev(9'h100, 1);
      rc(TX_CSR_OFS, 32'h0004_0000);
      wr(TX_CSR_OFS, 32'h0);
      ev(9'h004, 1);
      rc(TX_CSR_OFS, 32'h0);
      wr(CFG_OFS, 32'h2);
      ev(9'h004, 1);
      rc(TX_CSR_OFS, 32'h0080_0000);
      wr(TX_CSR_OFS, 32'h0);
      wr(CFG_OFS, 32'h0);
      // Double-buffered loads, send, toggle clear
      wr(TX_CSR_OFS, 32'h0001_0000);
      rc(TX_CSR_OFS, 32'h0002_0000);
      wr(TX_CSR_OFS, 32'h0001_0000);
      rc(TX_CSR_OFS, 32'h0003_0000);
      chk("avail", 32'h1, {31'h0, ctl.tx_pkt_avail});
      ev(9'h020, 1);
      rc(TX_CSR_OFS, 32'h0002_0000);
      chk("toggle", 32'h1, {31'h0, ctl.data_toggle});
      wr(TX_CSR_OFS, 32'h0040_0000);
      @(negedge clk);
      chk("toggle", 32'h0, {31'h0, ctl.data_toggle});
      f0 = fl;
      i0 = irq;
      wr(TX_CSR_OFS, 32'h0008_0000);
      rc(TX_CSR_OFS, 32'h0);
      chk("flush", {24'h0, f0 + 8'h01}, {24'h0, fl});
      chk("irq", {24'h0, i0 + 8'h01}, {24'h0, irq});
      // Stall requested, then STALL sent with a packet queued
      wr(TX_CSR_OFS, 32'h0011_0000);
      @(negedge clk);
      chk("stall", 32'h1, {31'h0, ctl.respond_stall});
      f0 = fl;
      ev(9'h080, 1);
      rc(TX_CSR_OFS, 32'h0030_0000);
      chk("flush", {24'h0, f0 + 8'h01}, {24'h0, fl});
      wr(TX_CSR_OFS, 32'h0);
      // Host role, NAK limit two
      wr(CFG_OFS, 32'h0000_0201);
      ev(9'h008, 2);
      rc(TX_CSR_OFS, 32'h0);
      ev(9'h008, 1);
      rc(TX_CSR_OFS, 32'h0080_0000);
      chk("halt", 32'h1, {31'h0, ctl.tx_halt});
      wr(TX_CSR_OFS, 32'h0);
      ev(9'h010, 2);
      rc(TX_CSR_OFS, 32'h0);
      ev(9'h010, 1);
      rc(TX_CSR_OFS, 32'h0004_0000);
      wr(TX_CSR_OFS, 32'h0);
      f0 = ab;
      ev(9'h040, 1);
      rc(TX_CSR_OFS, 32'h0020_0000);
      chk("abort", {24'h0, f0 + 8'h01}, {24'h0, ab});
      wr(TX_CSR_OFS, 32'h0001_0000);
      ev(9'h020, 1);
      // Setup select with a load: both bits of the pair are high
      wr(TX_CSR_OFS, 32'h0011_0000);
      @(negedge clk);
      chk("setup tog", 32'h3, {30'h0, ctl.send_setup, ~ctl.data_toggle});
      i0 = irq;
      ev(9'h001, 3);
      rc(RX_CSR_OFS, 32'h0004_0000);
      chk("irq", {24'h0, i0 + 8'h01}, {24'h0, irq});
      wr(RX_CSR_OFS, 32'h0);
      // Peripheral iso receive: fill, overrun, unload
      wr(CFG_OFS, 32'h8);
      ev(9'h002, 1);
      rc(RX_CSR_OFS, 32'h0001_0000);
      ev(9'h002, 1);
      rc(RX_CSR_OFS, 32'h0003_0000);
      chk("rx full", 32'h1, {31'h0, ctl.rx_full});
      ev(9'h002, 1);
      rc(RX_CSR_OFS, 32'h0007_0000);
      wr(RX_CSR_OFS, 32'h0004_0000);
      rc(RX_CSR_OFS, 32'h0005_0000);
      wr(RX_CSR_OFS, 32'h0);
      rc(RX_CSR_OFS, 32'h0);
      // Mid-run reset with a packet and a stall request pending
      wr(TX_CSR_OFS, 32'h0011_0000);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rc(TX_CSR_OFS, RDATA_RST);
      chk("ctl", 32'h0, {31'h0, |ctl});
      test_done();
   end
endmodule
`default_nettype wire
